// [abu_pkg.sv]
package abu_pkg;

	// register word offsets (byte addresses on the wishbone bus)
	localparam logic [3:0] OFS_CTRL_STATUS = 4'h0;
	localparam logic [3:0] OFS_ADDR_HIGH = 4'h4;
	localparam logic [3:0] OFS_ADDR_LOW = 4'h8;
	localparam logic [3:0] OFS_AUXILIARY = 4'hc;
	localparam logic [4:0] OFS_WAIT_STATUS = 5'h10;
	localparam logic [4:0] OFS_FLAG_CONTROL = 5'h14;

	// field positions
	localparam int BIT_MATCH_ENABLE = 7;
	localparam int BIT_ACTIVE = 6;
	localparam int BIT_WDOG_DISABLE = 0;
	localparam int BIT_WAIT_EXIT = 1;
	localparam int BIT_CLEAR_FLAG_EN = 7;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// break vectors
	localparam logic [15:0] VEC_NORMAL = 16'hfffc;
	localparam logic [15:0] VEC_MONITOR = 16'hfefc;
	localparam logic [7:0] SWI_OPCODE_DEFAULT = 8'h83;

	typedef struct packed
	{
		logic fetch;
		logic opcode_fetch;
		logic instr_start;
		logic rti_exec;
		logic [15:0] addr;
	} abu_cpu_s;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_PEND = 2'b01,
		ST_BREAK = 2'b10
	} abu_state_e;

endpackage : abu_pkg

// [abu_break_unit.sv]
`timescale 1ns/1ps
module abu_break_unit
#(
	parameter logic [7:0] SWI_OPCODE = abu_pkg::SWI_OPCODE_DEFAULT
)
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire abu_pkg::abu_cpu_s cpu_i,
	input wire logic monitor_mode,
	input wire logic wait_mode,
	output logic breakpoint_request,
	output logic force_swi,
	output logic [7:0] swi_opcode,
	output logic [15:0] break_vector,
	output logic break_state,
	output logic status_clear_allowed,
	output logic timer_stop,
	output logic watchdog_hold
);

	// ========================================================
	// registers
	logic match_enable_r;
	logic active_r;
	logic [7:0] addr_high_r;
	logic [7:0] addr_low_r;
	logic wdog_disable_r;
	logic wait_exit_r;
	logic clear_flag_en_r;
	logic rearm_block_r;
	abu_pkg::abu_state_e state_r;
	abu_pkg::abu_state_e state_nxt;
	logic sw_req_r;
	logic addr_moved_r;
	logic wait_exit_nxt;

	logic access;
	logic wr;
	logic hit;
	logic match;
	logic wr_ctrl;
	logic [31:0] rd_nxt;
	logic known;
	logic wr_high;
	logic wr_low;
	logic wr_aux;
	logic wr_flag;
	logic in_idle;
	logic in_pend;
	logic in_break;

	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wr = access && wb_we_i && wb_sel_i[0];
	assign wr_ctrl = wr && (wb_adr_i == {1'b0, abu_pkg::OFS_CTRL_STATUS});
	assign wr_high = wr && (wb_adr_i == {1'b0, abu_pkg::OFS_ADDR_HIGH});
	assign wr_low = wr && (wb_adr_i == {1'b0, abu_pkg::OFS_ADDR_LOW});
	assign wr_aux = wr && (wb_adr_i == {1'b0, abu_pkg::OFS_AUXILIARY});
	assign wr_flag = wr && (wb_adr_i == abu_pkg::OFS_FLAG_CONTROL);

	// state decode shared by the output flops
	assign in_idle = state_r == abu_pkg::ST_IDLE;
	assign in_pend = state_r == abu_pkg::ST_PEND;
	assign in_break = state_r == abu_pkg::ST_BREAK;

	// ========================================================
	// address compare
	// fetch-only compare; opcode hits stop the instruction, operand hits
	// let it finish and take the break at the next instruction boundary
	assign hit = cpu_i.fetch && match_enable_r && !wait_mode
		&& (cpu_i.addr == {addr_high_r, addr_low_r});
	// a cleared flag with an unchanged address stays quiet until rearmed
	assign match = hit && !rearm_block_r;

	// ========================================================
	// bus decode
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		known = 1'b1;
		case (wb_adr_i)
			{1'b0, abu_pkg::OFS_CTRL_STATUS}:
			begin
				rd_nxt[abu_pkg::BIT_MATCH_ENABLE] = match_enable_r;
				rd_nxt[abu_pkg::BIT_ACTIVE] = active_r;
			end
			{1'b0, abu_pkg::OFS_ADDR_HIGH}: rd_nxt[7:0] = addr_high_r;
			{1'b0, abu_pkg::OFS_ADDR_LOW}: rd_nxt[7:0] = addr_low_r;
			{1'b0, abu_pkg::OFS_AUXILIARY}:
				rd_nxt[abu_pkg::BIT_WDOG_DISABLE] = wdog_disable_r;
			abu_pkg::OFS_WAIT_STATUS:
				rd_nxt[abu_pkg::BIT_WAIT_EXIT] = wait_exit_r;
			abu_pkg::OFS_FLAG_CONTROL:
				rd_nxt[abu_pkg::BIT_CLEAR_FLAG_EN] = clear_flag_en_r;
			default: known = 1'b0;
		endcase
	end

	// ack and err are single-cycle pulses; the access term drops them
	// while the master still holds cyc, so each request answers once
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= access && known;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			wb_err_o <= 1'b0;
		else
			wb_err_o <= access && !known;
	end

	// read data is zero outside the answer cycle
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			wb_dat_o <= 32'h0000_0000;
		else
			wb_dat_o <= (access && !wb_we_i) ? rd_nxt : 32'h0000_0000;
	end

	// ========================================================
	// software registers
	// each field has its own flop; a write with sel[0] low is acked but
	// leaves every field as it was
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			match_enable_r <= 1'b0;
		else if (wr_ctrl)
			match_enable_r <= wb_dat_i[abu_pkg::BIT_MATCH_ENABLE];
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			addr_high_r <= abu_pkg::RST_BYTE;
		else if (wr_high)
			addr_high_r <= wb_dat_i[7:0];
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			addr_low_r <= abu_pkg::RST_BYTE;
		else if (wr_low)
			addr_low_r <= wb_dat_i[7:0];
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			wdog_disable_r <= 1'b0;
		else if (wr_aux)
			wdog_disable_r <= wb_dat_i[abu_pkg::BIT_WDOG_DISABLE];
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			clear_flag_en_r <= 1'b0;
		else if (wr_flag)
			clear_flag_en_r <= wb_dat_i[abu_pkg::BIT_CLEAR_FLAG_EN];
	end

	// ========================================================
	// active flag: a match sets it and wins over a clearing write
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			active_r <= 1'b0;
		else if (match)
			active_r <= 1'b1;
		else if (wr_ctrl)
			active_r <= wb_dat_i[abu_pkg::BIT_ACTIVE];
	end

	// an address written inside the current break counts as an update, so
	// clearing the flag afterwards does not block the new address
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			addr_moved_r <= 1'b0;
		else if (wr_high || wr_low)
			addr_moved_r <= 1'b1;
		else if (!in_break)
			addr_moved_r <= 1'b0;
	end

	// cleared by software inside the break with the address untouched:
	// block the same address from re-firing until it is rewritten
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			rearm_block_r <= 1'b0;
		else if (wr_high || wr_low)
			rearm_block_r <= 1'b0;
		else if (wr_ctrl && in_break && !addr_moved_r
			&& !wb_dat_i[abu_pkg::BIT_ACTIVE])
			rearm_block_r <= 1'b1;
	end

	// software request waits for the next instruction boundary
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			sw_req_r <= 1'b0;
		else if (wr_ctrl && wb_dat_i[abu_pkg::BIT_ACTIVE])
			sw_req_r <= 1'b1;
		else if (cpu_i.instr_start)
			sw_req_r <= 1'b0;
	end

	// ========================================================
	// break sequence
	// a software request at an instruction boundary wins over an operand
	// hit, so a raised request is always followed by the break state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			abu_pkg::ST_IDLE:
				if ((match && cpu_i.opcode_fetch)
					|| (sw_req_r && cpu_i.instr_start))
					state_nxt = abu_pkg::ST_BREAK;
				else if (match)
					state_nxt = abu_pkg::ST_PEND;
			abu_pkg::ST_PEND:
				if (cpu_i.instr_start)
					state_nxt = abu_pkg::ST_BREAK;
			abu_pkg::ST_BREAK:
				if (cpu_i.rti_exec)
					state_nxt = abu_pkg::ST_IDLE;
			default: state_nxt = abu_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			state_r <= abu_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// ========================================================
	// wait exit status
	// address hits cannot happen in wait, so in practice only the
	// software request sets this flag; the return ends it
	always_comb
	begin
		wait_exit_nxt = wait_exit_r;
		if (in_idle && (match || sw_req_r) && wait_mode)
			wait_exit_nxt = 1'b1;
		else if (in_break && cpu_i.rti_exec)
			wait_exit_nxt = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			wait_exit_r <= 1'b0;
		else
			wait_exit_r <= wait_exit_nxt;
	end

	// ========================================================
	// outputs toward the cpu and system integration unit
	// the request pulses once per break; the sequencer leaves idle or
	// pending on the same edge, so it cannot repeat
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			breakpoint_request <= 1'b0;
		else
			breakpoint_request <= (in_idle && match
				&& cpu_i.opcode_fetch) || (!in_break
				&& cpu_i.instr_start
				&& (sw_req_r || in_pend));
	end

	// opcode hits only: an operand hit lets the fetched opcode run
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			force_swi <= 1'b0;
		else
			force_swi <= in_idle && match
				&& cpu_i.opcode_fetch;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			swi_opcode <= abu_pkg::RST_BYTE;
		else
			swi_opcode <= SWI_OPCODE;
	end

	// the vector follows the mode every cycle, so it is ready whenever
	// the integration unit takes the break
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			break_vector <= abu_pkg::VEC_NORMAL;
		else
			break_vector <= monitor_mode ? abu_pkg::VEC_MONITOR
				: abu_pkg::VEC_NORMAL;
	end

	// ========================================================
	// break-time controls; the watchdog hold only in monitor mode with wdog_disable_r set
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			break_state <= 1'b0;
		else
			break_state <= in_break;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			status_clear_allowed <= 1'b1;
		else
			status_clear_allowed <= !in_break || clear_flag_en_r;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			timer_stop <= 1'b0;
		else
			timer_stop <= in_break;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			watchdog_hold <= 1'b0;
		else
			watchdog_hold <= in_break && monitor_mode
				&& wdog_disable_r;
	end

endmodule : abu_break_unit

// [abu_chk_sva.sv]
`timescale 1ns/1ps
module abu_chk
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire abu_pkg::abu_cpu_s cpu_i,
	input wire logic monitor_mode,
	input wire logic wait_mode,
	input wire logic breakpoint_request,
	input wire logic force_swi,
	input wire logic [15:0] break_vector,
	input wire logic break_state,
	input wire logic status_clear_allowed,
	input wire logic timer_stop,
	input wire logic watchdog_hold
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// ==========
	// break entry and exit
	sequence s_enter;
		breakpoint_request ##1 (break_state && timer_stop);
	endsequence
	chk_swi_cause: assert property (force_swi |-> $past(cpu_i.fetch
		&& cpu_i.opcode_fetch && !wait_mode)) else $error("swi without fetch");
	chk_swi_enter: assert property (force_swi
		|-> s_enter) else $error("swi not followed by break");
	chk_req_pulse: assert property (breakpoint_request
		|=> !breakpoint_request) else $error("request too long");
	chk_vec_mode: assert property (1'b1 |=> break_vector == ($past(monitor_mode)
		? abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL)) else $error("bad vector");
	chk_timer_hold: assert property (timer_stop
		== break_state) else $error("timer stop differs from break");
	chk_rti_exit: assert property (break_state && cpu_i.rti_exec
		|-> ##2 !break_state) else $error("break outlived rti");
	chk_clear_idle: assert property (!break_state [*2]
		|-> status_clear_allowed) else $error("clear blocked outside break");
	chk_wdog_idle: assert property (!break_state [*2]
		|-> !watchdog_hold) else $error("watchdog held outside break");
endmodule : abu_chk

bind abu_break_unit abu_chk u_abu_chk (.*);

// [abu_cpu_model.sv]
`timescale 1ns/1ps
// ==========
// cpu fetch model: two-byte instructions, opcode at even addresses
module abu_cpu_model
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic run,
	input wire logic [15:0] start_pc,
	input wire logic [3:0] rti_wait,
	input wire logic break_state,
	output abu_pkg::abu_cpu_s cpu_o
);
	logic [15:0] pc_r;
	logic [3:0] cnt_r;
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn)
		begin
			pc_r <= 16'h0000;
			cnt_r <= 4'h0;
			cpu_o <= '0;
		end
		else if (!run || break_state)
		begin
			pc_r <= run ? pc_r : start_pc;
			// idle bus drops fetch, so the stale address it shows every other cycle cannot fake a match
			cpu_o <= {3'b000, break_state && cnt_r == rti_wait, ~cpu_o.addr};
			cnt_r <= (!break_state || cnt_r == rti_wait) ? 4'h0 : cnt_r + 4'h1;
		end
		else
		begin
			pc_r <= pc_r + 16'h0001;
			cpu_o <= {1'b1, !pc_r[0], !pc_r[0], 1'b0, pc_r};
			cnt_r <= 4'h0;
		end
endmodule : abu_cpu_model

// [abu_tb.sv]
`timescale 1ns/1ps
module testbench;
	logic clk_sys, resetn, cyc, we, run, mon, wm, e;
	logic ack, err, req, software_interrupt_opcode, bst, sca, tst, wdh;
	logic [4:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [7:0] opc;
	logic [15:0] vec;
	abu_pkg::abu_cpu_s cpu;
	int err_total, checks_done, hits;
	abu_break_unit u_abu_break_unit
	(
		.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .cpu_i(cpu),
		.monitor_mode(mon), .wait_mode(wm), .breakpoint_request(req),
		.force_swi(software_interrupt_opcode), .swi_opcode(opc), .break_vector(vec),
		.break_state(bst), .status_clear_allowed(sca), .timer_stop(tst),
		.watchdog_hold(wdh)
	);
	abu_cpu_model u_abu_cpu_model
	(
		.clk_sys(clk_sys), .resetn(resetn), .run(run), .start_pc(16'h1230),
		.rti_wait(4'hf), .break_state(bst), .cpu_o(cpu)
	);
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ==========
	// checking, bus and wait helpers
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task test_done(input logic hang);
		if (hang)
			err_total++;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	// k: 0 bus answer, 1 break request, 2 break over
	task hold(input int k);
		int n;
		n = 0;
		while (!(k == 0 ? (ack || err) : k == 1 ? req : !bst) && n < 40)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n == 40)
			test_done(1'b1);
	endtask : hold
	task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		hold(0);
		q = rdat;
		e = err;
		cyc <= 1'b0;
	endtask : bus
	task rd(input logic [4:0] a, input logic [7:0] x);
		bus(1'b0, a, 8'h00);
		chk("rd", q, {24'h000000, x});
	endtask : rd
	initial
	begin
		{cyc, we, run, mon, wm, resetn} = 6'h00;
		adr = 5'h00;
		wdat = 32'h00000000;
		{err_total, checks_done, hits} = 0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(5'(4 * i), 8'h00);
		chk("opc", opc, abu_pkg::SWI_OPCODE_DEFAULT);
		bus(1'b0, 5'h18, 8'h00);
		chk("err", e, 1'b1);
		bus(1'b1, 5'h04, 8'h12);
		bus(1'b1, 5'h08, 8'h34);
		bus(1'b1, 5'h0c, 8'h01);
		bus(1'b1, 5'h00, 8'h80);
		rd(5'h04, 8'h12);
		mon <= 1'b1;
		run <= 1'b1;
		hold(1);
		chk("swi", software_interrupt_opcode, 1'b1);
		rd(5'h00, 8'hc0);
		chk("tmr", tst, 1'b1);
		chk("wdg", wdh, 1'b1);
		chk("clr", sca, 1'b0);
		chk("vec", vec, abu_pkg::VEC_MONITOR);
		bus(1'b1, 5'h00, 8'h80);
		hold(2);
		run <= 1'b0;
		@(posedge clk_sys);
		run <= 1'b1;
		repeat (20) @(posedge clk_sys) hits += int'(req);
		chk("again", hits, 0);
		run <= 1'b0;
		bus(1'b1, 5'h08, 8'h37);
		run <= 1'b1;
		hold(1);
		chk("swi", software_interrupt_opcode, 1'b0);
		bus(1'b1, 5'h00, 8'h00);
		hold(2);
		bus(1'b1, 5'h00, 8'h40);
		hold(1);
		chk("swi", software_interrupt_opcode, 1'b0);
		bus(1'b1, 5'h14, 8'h80);
		rd(5'h14, 8'h80);
		chk("brk", bst, 1'b1);
		chk("clr", sca, 1'b1);
		hold(2);
		wm <= 1'b1;
		bus(1'b1, 5'h00, 8'h40);
		hold(1);
		wm <= 1'b0;
		rd(5'h10, 8'h02);
		hold(2);
		rd(5'h10, 8'h00);
		bus(1'b1, 5'h04, 8'h5a);
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(5'h04, 8'h00);
		rd(5'h00, 8'h00);
		rd(5'h0c, 8'h00);
		test_done(1'b0);
	end
endmodule : testbench
